// >>> sms_pkg.sv
// sms_pkg: constants, register map and types for the spi shifter block.
// assumes a single system clock and a classic wishbone register slave.
//
// Function
// - select going high clears bit count, sets incomplete flag, raises interrupt
// - clock_idle_low picks idle sck level: 0 high, 1 low
// - capture_edge_sel with idle level picks rising or falling capture edge
// - msb_first 1 shifts msb first, 0 shifts lsb first
// - select_pin_en 0 floats the select pin, 1 uses it as select
// - data write during transfer is discarded and sets write_collision
// - write_collision and select_pin_en are removable by static option
// - xfer_done set at end of transfer, held until software clears it
// - master mode: data write starts full-duplex transfer
// - slave mode: external clock edges shift data out and in
// - slave output bit valid at select per idle level and edge
// - slave with select_pin_en 0 stays selected, ignores select pin
// - spi keeps running in idle mode
// - control bits 7 and 6 are plain read/write storage
// - mode_select picks master clock rate, slave, i2c or unused
// - iface_enable 0 floats pins; settings kept when re-enabled
package sms_pkg;

  // ==========================================================
  // register map (byte addresses on wishbone)
  localparam logic [3:0] SMS_ADDR_MODE  = 4'h0;
  localparam logic [3:0] SMS_ADDR_CTRL  = 4'h4;
  localparam logic [3:0] SMS_ADDR_DATA  = 4'h8;
  localparam logic [3:0] SMS_ADDR_IRQST = 4'hC;
  localparam logic [3:0] SMS_ADDR_IRQMK = 4'h0;
  localparam logic       SMS_HI_MASK    = 1'h1;

  // ==========================================================
  // mode_ctrl_reg fields
  localparam int SMS_MODE_LSB   = 5;
  localparam int SMS_ENABLE_BIT = 1;
  localparam int SMS_INCMP_BIT  = 0;
  localparam logic [7:0] SMS_MODE_RESET = 8'hE0;
  localparam logic [7:0] SMS_MODE_WMASK = 8'hEF;

  // spi_ctrl_reg fields
  localparam int SMS_IDLELOW_BIT = 5;
  localparam int SMS_EDGE_BIT    = 4;
  localparam int SMS_MSB_BIT     = 3;
  localparam int SMS_SELEN_BIT   = 2;
  localparam int SMS_WRITE_COLLISION_BIT    = 1;
  localparam int SMS_DONE_BIT    = 0;
  localparam logic [7:0] SMS_CTRL_RESET = 8'h00;

  // irq status/mask bits
  localparam int SMS_IRQ_DONE  = 0;
  localparam int SMS_IRQ_INCMP = 1;
  localparam int SMS_IRQ_WRITE_COLLISION  = 2;

  // ==========================================================
  // timing: master divider half periods minus one, in system clocks
  localparam logic [5:0] SMS_HALF_DIV4  = 6'h01;
  localparam logic [5:0] SMS_HALF_DIV16 = 6'h07;
  localparam logic [5:0] SMS_HALF_DIV64 = 6'h1F;
  localparam logic [3:0] SMS_BITS       = 4'h8;

  typedef enum logic [2:0] {
    SMS_M_DIV4  = 3'b000,
    SMS_M_DIV16 = 3'b001,
    SMS_M_DIV64 = 3'b010,
    SMS_M_SUB   = 3'b011,
    SMS_M_TMR   = 3'b100,
    SMS_SLAVE   = 3'b101,
    SMS_I2C     = 3'b110,
    SMS_UNUSED  = 3'b111
  } sms_mode_e;

  typedef enum logic [1:0] {
    SMS_IDLE  = 2'b00,
    SMS_LEAD  = 2'b01,
    SMS_TRAIL = 2'b10
  } sms_state_e;

  // pin group toward the spi peer
  typedef struct packed {
    logic sckOut;
    logic sckOe_n;
    logic serialOut;
    logic serialOutOe_n;
  } sms_pins_s;

endpackage : sms_pkg

// >>> sms_spi_shifter.sv
// sms_spi_shifter: spi master/slave byte shifter with wishbone registers.
// assumes pins are synchronised here; sub clock and timer ticks are
// single-cycle pulses on the system clock.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sms_spi_shifter
  import sms_pkg::*;
#(
  parameter bit HAS_WRITE_COLLISION  = 1'b1,
  parameter bit HAS_SELEN = 1'b1
) (
  // system
  input  wire logic        clock,
  input  wire logic        srst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // rate ticks for sub clock and timer modes
  input  wire logic        subTick,
  input  wire logic        timerZeroTick,
  // spi pins
  input  wire logic        sckIn,
  input  wire logic        serialIn,
  input  wire logic        slaveSelectIn_n,
  output sms_pins_s        pins,
  output logic             selectPinOe_n,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // register state
  logic [7:0] modeCtrl_reg;
  logic [7:0] spiCtrl_reg;
  logic [7:0] shiftData_reg;
  logic [2:0] irqStat_reg;
  logic [2:0] irqMask_reg;
  logic       ack_reg;
  logic [31:0] rdData_reg;

  // ==========================================================
  // pin synchronisers; first stage read only by second
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic       sckPrev_reg;
  logic       selPrev_reg;
  always_ff @(posedge clock) begin
    syncA_reg <= {sckIn, serialIn, slaveSelectIn_n};
    syncB_reg <= syncA_reg;
  end
  wire logic sckS   = syncB_reg[2];
  wire logic sdiS   = syncB_reg[1];
  wire logic selS_n = syncB_reg[0];

  // ==========================================================
  // decode
  wire logic       enable   = modeCtrl_reg[SMS_ENABLE_BIT];
  wire sms_mode_e  mode     = sms_mode_e'(modeCtrl_reg[7:SMS_MODE_LSB]);
  wire logic       isSlave  = enable && (mode == SMS_SLAVE);
  wire logic       isMaster = enable && (mode <= SMS_M_TMR);
  wire logic       idleLow  = spiCtrl_reg[SMS_IDLELOW_BIT];
  wire logic       edgeSel  = spiCtrl_reg[SMS_EDGE_BIT];
  wire logic       msbFirst = spiCtrl_reg[SMS_MSB_BIT];
  wire logic       selEn    = HAS_SELEN && spiCtrl_reg[SMS_SELEN_BIT];
  wire logic       wbReq    = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic       wbWr     = wbReq && wb_we_i && wb_sel_i[0];
  wire logic       wrMode   = wbWr && (wb_adr_i == SMS_ADDR_MODE);
  wire logic       wrCtrl   = wbWr && (wb_adr_i == SMS_ADDR_CTRL);
  wire logic       wrData   = wbWr && (wb_adr_i == SMS_ADDR_DATA);
  wire logic       wrIrqSt  = wbWr && (wb_adr_i == SMS_ADDR_IRQST);
  wire logic       wrIrqMk  = wbWr && (wb_adr_i == SMS_ADDR_IRQMK) && SMS_HI_MASK && wb_dat_i[31];

  // ==========================================================
  // shifter state
  sms_state_e state_reg;
  logic [3:0] bitCnt_reg;
  logic [5:0] divCnt_reg;
  logic       sckOut_reg;
  logic       outBit_reg;
  logic       inBit_reg;

  // with pin disabled slave stays selected
  wire logic selected = isSlave && (!selEn || !selS_n);
  wire logic busy     = (state_reg != SMS_IDLE) || (isSlave && selected && bitCnt_reg != 4'h0);

  // edges in clock-idle terms: leading edge leaves idle level
  wire logic sckRise  = sckS && !sckPrev_reg;
  wire logic sckFall  = !sckS && sckPrev_reg;
  wire logic leadEdge = idleLow ? sckRise : sckFall;
  wire logic trailEdge = idleLow ? sckFall : sckRise;
  // edgeSel 0 samples on trailing edge, 1 on leading (maps to table)
  wire logic slvSample = selected && (edgeSel ? leadEdge : trailEdge);
  wire logic slvShift  = selected && (edgeSel ? trailEdge : leadEdge);

  // master half-period tick
  logic [5:0] halfDiv;
  always_comb begin
    unique case (mode)
      SMS_M_DIV4:  halfDiv = SMS_HALF_DIV4;
      SMS_M_DIV16: halfDiv = SMS_HALF_DIV16;
      SMS_M_DIV64: halfDiv = SMS_HALF_DIV64;
      default:     halfDiv = 6'h00;
    endcase
  end
  wire logic rateTick = (mode == SMS_M_SUB) ? subTick :
                        (mode == SMS_M_TMR) ? timerZeroTick :
                        (divCnt_reg == halfDiv);
  wire logic mTick = (state_reg != SMS_IDLE) && rateTick;

  wire logic txBit = msbFirst ? shiftData_reg[7] : shiftData_reg[0];
  wire logic [7:0] shifted = msbFirst ? {shiftData_reg[6:0], inBit_reg}
                                      : {inBit_reg, shiftData_reg[7:1]};
  // leading capture shifts on the same edge that launches the next bit
  wire logic txNext  = msbFirst ? shiftData_reg[6] : shiftData_reg[1];
  wire logic nextOut = edgeSel ? txNext : txBit;

  // master: sample on first half if edgeSel picks leading-equivalent
  wire logic mSample = mTick && ((state_reg == SMS_LEAD) == edgeSel) ;
  wire logic mShiftT = mTick && ((state_reg == SMS_TRAIL) == edgeSel);
  wire logic mLast   = mTick && state_reg == SMS_TRAIL && bitCnt_reg == SMS_BITS - 4'h1;
  wire logic sLast   = slvShift && bitCnt_reg == SMS_BITS && edgeSel;
  wire logic sLastS  = slvSample && bitCnt_reg == SMS_BITS - 4'h1 && !edgeSel;
  wire logic doneEv  = mLast || sLast || sLastS;
  wire logic selRise = isSlave && selEn && selS_n && !selPrev_reg;
  wire logic wcolEv  = HAS_WRITE_COLLISION && wrData && busy;

  // ==========================================================
  // transfer engine
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg   <= SMS_IDLE;
      bitCnt_reg  <= 4'h0;
      divCnt_reg  <= 6'h00;
      sckOut_reg  <= 1'b1;
      sckPrev_reg <= 1'b1;
      selPrev_reg <= 1'b1;
      inBit_reg   <= 1'b0;
      outBit_reg  <= 1'b0;
    end else begin
      sckPrev_reg <= sckS;
      selPrev_reg <= selS_n;
      divCnt_reg  <= (state_reg == SMS_IDLE || rateTick) ? 6'h00 : divCnt_reg + 6'h01;
      if (state_reg == SMS_IDLE) begin
        sckOut_reg <= ~idleLow;
      end
      if (isMaster && wrData && !busy) begin
        state_reg  <= SMS_LEAD;
        bitCnt_reg <= 4'h0;
        outBit_reg <= msbFirst ? wb_dat_i[7] : wb_dat_i[0];
      end else if (mTick) begin
        sckOut_reg <= ~sckOut_reg;
        if (mSample) begin
          inBit_reg <= sdiS;
        end
        if (state_reg == SMS_LEAD) begin
          state_reg <= SMS_TRAIL;
        end else begin
          bitCnt_reg <= bitCnt_reg + 4'h1;
          state_reg  <= mLast ? SMS_IDLE : SMS_LEAD;
        end
      end
      if (isSlave) begin
        if (selRise || !selected) begin
          bitCnt_reg <= 4'h0;
          // first bit ready as soon as selected
          outBit_reg <= txBit;
        end else begin
          if (slvSample) begin
            inBit_reg  <= sdiS;
            bitCnt_reg <= (bitCnt_reg == SMS_BITS - 4'h1 && !edgeSel) ? 4'h0 : bitCnt_reg + 4'h1;
          end
          if (slvShift && !(bitCnt_reg == 4'h0 && edgeSel)) begin
            outBit_reg <= nextOut;
          end
          if (sLast) begin
            bitCnt_reg <= 4'h0;
          end
        end
      end
      if (mShiftT && !mLast) begin
        outBit_reg <= nextOut;
      end
      if (!enable) begin
        // disable stops the engine, keeps settings
        state_reg  <= SMS_IDLE;
        bitCnt_reg <= 4'h0;
      end
    end
  end

  // ==========================================================
  // registers and data shift
  // slave shift, master shift share one data register
  wire logic slvMove = isSlave && !selRise && selected &&
                       ((edgeSel && slvShift && bitCnt_reg != 4'h0) || (!edgeSel && slvSample));
  wire logic mstMove = (mTick && state_reg == SMS_TRAIL && !edgeSel) ||
                       (mTick && state_reg == SMS_LEAD && edgeSel && 1'b0) ||
                       (mTick && state_reg == SMS_TRAIL && edgeSel);
  wire logic [7:0] slvIn = msbFirst ? {shiftData_reg[6:0], sdiS} : {sdiS, shiftData_reg[7:1]};

  always_ff @(posedge clock) begin
    if (srst) begin
      modeCtrl_reg  <= SMS_MODE_RESET;
      spiCtrl_reg   <= SMS_CTRL_RESET;
      shiftData_reg <= 8'h00;
      irqStat_reg   <= 3'h0;
      irqMask_reg   <= 3'h0;
    end else begin
      if (wrMode) begin
        modeCtrl_reg <= wb_dat_i[7:0] & SMS_MODE_WMASK;
      end
      if (wrCtrl) begin
        spiCtrl_reg <= wb_dat_i[7:0];
      end
      if (wrData && !busy) begin
        shiftData_reg <= wb_dat_i[7:0];
      end else if (slvMove && !edgeSel) begin
        shiftData_reg <= slvIn;
      end else if (slvMove) begin
        shiftData_reg <= shifted;
      end else if (mstMove) begin
        // leading capture waits in inBit; trailing capture is taken live
        shiftData_reg <= edgeSel ? shifted : slvIn;
      end
      // done flag sticky; set wins over clear
      if (doneEv) begin
        spiCtrl_reg[SMS_DONE_BIT] <= 1'b1;
      end
      if (wcolEv) begin
        spiCtrl_reg[SMS_WRITE_COLLISION_BIT] <= 1'b1;
      end
      if (!HAS_WRITE_COLLISION) begin
        spiCtrl_reg[SMS_WRITE_COLLISION_BIT] <= 1'b0;
      end
      if (!HAS_SELEN) begin
        spiCtrl_reg[SMS_SELEN_BIT] <= 1'b0;
      end
      if (selRise) begin
        modeCtrl_reg[SMS_INCMP_BIT] <= 1'b1;
      end
      if (wrIrqMk) begin
        irqMask_reg <= wb_dat_i[2:0];
      end
      irqStat_reg <= (irqStat_reg & ~(wrIrqSt ? wb_dat_i[2:0] : 3'h0)) |
                     {wcolEv, selRise, doneEv};
    end
  end

  // ==========================================================
  // wishbone answer: one cycle after request
  logic [31:0] rdMux;
  always_comb begin
    unique case (wb_adr_i)
      SMS_ADDR_MODE:  rdMux = {irqMask_reg[0], 23'h0, modeCtrl_reg};
      SMS_ADDR_CTRL:  rdMux = {24'h0, spiCtrl_reg};
      SMS_ADDR_DATA:  rdMux = {24'h0, shiftData_reg};
      SMS_ADDR_IRQST: rdMux = {21'h0, irqMask_reg, 5'h0, irqStat_reg};
      default:        rdMux = 32'h0;
    endcase
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0;
    end else begin
      ack_reg    <= wbReq;
      rdData_reg <= rdMux;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  // ==========================================================
  // pins and interrupt
  // all pins float while disabled; no idle gating here
  assign pins.sckOut        = sckOut_reg;
  assign pins.sckOe_n       = !isMaster;
  assign pins.serialOut     = outBit_reg;
  assign pins.serialOutOe_n = !(isMaster || (isSlave && selected));
  // select pin floats when not used as select
  assign selectPinOe_n      = 1'b1;
  assign irq = |(irqStat_reg & irqMask_reg);

endmodule : sms_spi_shifter
`default_nettype wire

// >>> sms_spi_monitor.sv
// sms_spi_monitor: port-level checks for sms_spi_shifter.
// assumes register writes land at the taking edge, data on byte lane 0.
`timescale 1ns/1ps
`default_nettype none
module sms_spi_monitor
  import sms_pkg::*;
(
  // system
  input wire logic        clock,
  input wire logic        srst,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // pins
  input wire logic        slaveSelectIn_n,
  input wire sms_pins_s   pins,
  input wire logic        selectPinOe_n,
  input wire logic        irq
);
  // ==========================================================
  // shadows of written registers
  logic [7:0] modeSeen_reg;
  logic [7:0] ctrlSeen_reg;
  logic [4:0] edgeCnt_reg;
  logic       sckPrev_reg;
  wire        wrTake  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  wire        slaveOn = modeSeen_reg[7:5] == SMS_SLAVE && modeSeen_reg[SMS_ENABLE_BIT];
  wire        selEn   = ctrlSeen_reg[SMS_SELEN_BIT];
  always_ff @(posedge clock) begin
    if (srst) begin
      modeSeen_reg <= SMS_MODE_RESET;
      ctrlSeen_reg <= SMS_CTRL_RESET;
      edgeCnt_reg  <= 5'h00;
    end else begin
      if (wrTake && wb_adr_i == SMS_ADDR_MODE) modeSeen_reg <= wb_dat_i[7:0];
      if (wrTake && wb_adr_i == SMS_ADDR_CTRL) ctrlSeen_reg <= wb_dat_i[7:0];
      // count only restarts between transfers, not on a collision
      if (wrTake && wb_adr_i == SMS_ADDR_DATA && edgeCnt_reg == 5'h10) edgeCnt_reg <= 5'h00;
      else if (!pins.sckOe_n && pins.sckOut != sckPrev_reg) edgeCnt_reg <= edgeCnt_reg + 5'h01;
    end
    sckPrev_reg <= pins.sckOut;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  property p_ack_once;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single pulse");
  property p_sel_float;
    1'b1 |-> selectPinOe_n;
  endproperty
  a_sel_float: assert property (p_sel_float) else $error("select pin driven");
  property p_edges;
    edgeCnt_reg <= 5'h10;
  endproperty
  a_edges: assert property (p_edges) else $error("more than eight bits clocked");
  property p_idle;
    edgeCnt_reg == 5'h10 && !pins.sckOe_n |-> pins.sckOut == !ctrlSeen_reg[SMS_IDLELOW_BIT];
  endproperty
  a_idle: assert property (p_idle) else $error("sck not at idle level");
  property p_off;
    !modeSeen_reg[SMS_ENABLE_BIT] [*2] |-> pins.sckOe_n && pins.serialOutOe_n;
  endproperty
  a_off: assert property (p_off) else $error("pins driven while disabled");
  property p_slave_sck;
    slaveOn [*2] |-> pins.sckOe_n;
  endproperty
  a_slave_sck: assert property (p_slave_sck) else $error("slave drives sck");
  property p_deselect;
    (slaveOn && selEn && slaveSelectIn_n) [*5] |-> pins.serialOutOe_n;
  endproperty
  a_deselect: assert property (p_deselect) else $error("unselected slave drives out");
  property p_always_sel;
    (slaveOn && !selEn) [*5] |-> !pins.serialOutOe_n;
  endproperty
  a_always_sel: assert property (p_always_sel) else $error("slave not selected");
  c_done: cover property (edgeCnt_reg == 5'h10);
  c_irq: cover property ($rose(irq));
  c_slave: cover property (slaveOn && !pins.serialOutOe_n);
endmodule : sms_spi_monitor
bind sms_spi_shifter sms_spi_monitor sms_spi_monitor_i (.clock(clock), .srst(srst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .slaveSelectIn_n(slaveSelectIn_n), .pins(pins), .selectPinOe_n(selectPinOe_n), .irq(irq));
`default_nettype wire

// >>> sms_spi_peer.sv
// sms_spi_peer: behavioural spi slave facing the master-mode shifter.
// assumes idle-high sck, capture on rising edge, msb first.
`timescale 1ns/1ps
`default_nettype none
module sms_spi_peer (
  // spi wires
  input wire logic       sck,
  input wire logic       active_n,
  input wire logic       mosi,
  output logic           miso,
  // bytes
  input wire logic [7:0] reply,
  output logic     [7:0] got
);
  int idx = 0;
  initial miso = 1'b0;
  initial got = 8'h00;
  always @(negedge sck) if (!active_n && idx < 8) miso <= reply[7 - idx];
  always @(posedge sck) begin
    if (!active_n && idx < 8) begin
      got <= {got[6:0], mosi};
      idx <= idx + 1;
    end
  end
  // released line shows no stale bit
  always @(idx) if (idx == 8) miso <= ~miso;
endmodule : sms_spi_peer
`default_nettype wire

// >>> tb_top.sv
// tb_top: register-level tests of sms_spi_shifter in master and slave mode.
// assumes one 250 MHz clock; tb plays the spi master in slave tests.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sms_pkg::*;
  logic        clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, selectPinOe_n;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdata;
  logic        ssN, sckTb, slvIn, useSlave, peerMiso;
  logic [7:0]  peerGot, slvGot;
  sms_pins_s   pins;
  int          bad_count = 0;
  int          cmp_count = 0;
  sms_spi_shifter sms_spi_shifter_i (.clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .subTick(1'b0),
    .timerZeroTick(1'b0), .sckIn(sckTb), .serialIn(useSlave ? slvIn : peerMiso),
    .slaveSelectIn_n(ssN), .pins(pins), .selectPinOe_n(selectPinOe_n), .irq(irq));
  sms_spi_peer sms_spi_peer_i (.sck(pins.sckOut), .active_n(pins.sckOe_n),
    .mosi(pins.serialOut), .miso(peerMiso), .reply(8'h5B), .got(peerGot));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================
  // tasks
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wb
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rdc
  task automatic wait_done;
    for (int i = 0; i < 400; i++) begin
      wb(1'b0, SMS_ADDR_CTRL, 32'h0);
      if (rdata[SMS_DONE_BIT] === 1'b1) return;
    end
    bad_count++;
    tally_and_finish();
  endtask : wait_done
  task automatic spi_bits(input logic [7:0] b, input int n, input logic lo);
    @(posedge clock);
    sckTb <= ~lo;
    repeat (6) @(posedge clock);
    ssN <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      slvIn <= b[7 - i];
      sckTb <= 1'b0;
      repeat (10) @(posedge clock);
      slvGot = {slvGot[6:0], pins.serialOut};
      sckTb <= 1'b1;
      repeat (10) @(posedge clock);
    end
    // idle-low clock needs its closing trailing edge
    sckTb <= ~lo;
    repeat (10) @(posedge clock);
    ssN <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : spi_bits
  // ==========================================================
  // tests
  initial begin
    {srst, ssN, sckTb} = 3'b111;
    {wb_cyc_i, wb_stb_i, wb_we_i, slvIn, useSlave} = 5'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h00_0000_0000;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rdc(SMS_ADDR_MODE, 32'h0000_00E0);
    rdc(SMS_ADDR_CTRL, 32'h0000_0000);
    rdc(4'h2, 32'h0000_0000);
    wb(1'b1, SMS_ADDR_CTRL, 32'h0000_00C8);
    rdc(SMS_ADDR_CTRL, 32'h0000_00C8);
    $display("test registers done");
    wb(1'b1, SMS_ADDR_MODE, 32'h8000_0026);
    wb(1'b1, SMS_ADDR_DATA, 32'h0000_00A5);
    wb(1'b1, SMS_ADDR_DATA, 32'h0000_003C);
    rdc(SMS_ADDR_CTRL, 32'h0000_00CA);
    chk({31'h0, irq}, 32'h1);
    wait_done();
    rdc(SMS_ADDR_DATA, 32'h0000_005B);
    chk({24'h0, peerGot}, 32'h0000_00A5);
    chk({31'h0, pins.sckOut}, 32'h1);
    rdc(SMS_ADDR_IRQST, 32'h0000_0605);
    wb(1'b1, SMS_ADDR_IRQST, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, SMS_ADDR_CTRL, 32'h0000_0008);
    rdc(SMS_ADDR_CTRL, 32'h0000_0008);
    wb(1'b1, SMS_ADDR_MODE, 32'h0000_0024);
    rdc(SMS_ADDR_CTRL, 32'h0000_0008);
    $display("test master done");
    useSlave <= 1'b1;
    wb(1'b1, SMS_ADDR_CTRL, 32'h0000_000C);
    wb(1'b1, SMS_ADDR_MODE, 32'h0000_00A6);
    spi_bits(8'hFF, 3, 1'b0);
    rdc(SMS_ADDR_MODE, 32'h0000_00A7);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, SMS_ADDR_MODE, 32'h0000_00A6);
    wb(1'b1, SMS_ADDR_DATA, 32'h0000_0069);
    // a stale bit count would end this byte early
    spi_bits(8'h96, 8, 1'b0);
    rdc(SMS_ADDR_DATA, 32'h0000_0096);
    chk({24'h0, slvGot}, 32'h0000_0069);
    rdc(SMS_ADDR_CTRL, 32'h0000_000D);
    $display("test slave done");
    // idle low, leading capture, lsb first
    wb(1'b1, SMS_ADDR_CTRL, 32'h0000_0034);
    wb(1'b1, SMS_ADDR_DATA, 32'h0000_001E);
    spi_bits(8'h96, 8, 1'b1);
    rdc(SMS_ADDR_DATA, 32'h0000_0069);
    chk({24'h0, slvGot}, 32'h0000_0078);
    rdc(SMS_ADDR_CTRL, 32'h0000_0035);
    $display("test idle low done");
    wb(1'b1, SMS_ADDR_CTRL, 32'h0000_0008);
    repeat (8) @(posedge clock);
    chk({31'h0, pins.serialOutOe_n}, 32'h0);
    $display("test select done");
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
